// ==== core/ldos_pkg.sv ====
// Shared constants, states and carriers of the link delay and offset servo
package ldos_pkg;

	// ==========================================================
	// Time base, values in picoseconds except T_REF_NS, VAR_MAX_BITS, DRIFT_GAP_S and DRIFT_GAP_CYC
	localparam longint             CLK_PERIOD_PS = 10000;
	localparam logic signed [63:0] SEC_PS        = 64'sh0000_00E8_D4A5_1000;
	localparam longint             T_REF_NS      = 8;
	localparam logic signed [63:0] T_REF_PS      = 64'(T_REF_NS * 1000);
	localparam longint             BIT_PS        = 800;
	localparam longint             VAR_MAX_BITS  = 10;
	localparam logic signed [63:0] VAR_MAX_PS    = 64'(VAR_MAX_BITS * BIT_PS);
	localparam longint             DRIFT_GAP_S   = 3600;
	localparam longint             DRIFT_GAP_CYC =
		DRIFT_GAP_S * 64'sd1000000000000 / CLK_PERIOD_PS;

	// ==========================================================
	// Asymmetry coefficient, signed with 32 fraction bits
	localparam int                 FRAC_W    = 32;
	localparam logic signed [63:0] ALPHA_ONE = 64'sh0000_0001_0000_0000;
	// Index ratio of 1550 nm over 1310 nm minus one, 1.467/1.466 - 1
	localparam logic signed [63:0] ALPHA_RST = 64'sh0000_0000_002C_B436;

	// ==========================================================
	// Line coding and alignment search
	localparam logic [9:0] K28_CAL_PAT = 10'h3E0;
	localparam logic [9:0] COMMA_NEG   = 10'h0FA;
	localparam logic [9:0] COMMA_POS   = 10'h305;
	localparam logic [3:0] ALIGN_HITS  = 4'h4;
	localparam logic [3:0] WIN_LAST    = 4'hF;
	localparam logic [3:0] SLIP_WAIT   = 4'h3;
	localparam logic [3:0] SLIP_LAST   = 4'h9;

	// ==========================================================
	// Divider
	localparam logic [7:0] DIV_STEPS = 8'h80;

	// ==========================================================
	// States and kinds
	typedef enum logic [4:0] {
		C_IDLE = 5'b00001, C_TX = 5'b00010, C_RX = 5'b00100,
		C_DONE = 5'b01000, C_WAIT = 5'b10000
	} ldos_cal_st_t;

	typedef enum logic [6:0] {
		S_IDLE = 7'b0000001, S_DIV = 7'b0000010, S_MSD = 7'b0000100,
		S_SEC  = 7'b0001000, S_CYC = 7'b0010000, S_PH  = 7'b0100000,
		S_ACAL = 7'b1000000
	} ldos_srv_st_t;

	typedef enum logic [3:0] {
		K_SEC = 4'b0001, K_CYC = 4'b0010, K_PHASE = 4'b0100, K_DRIFT = 4'b1000
	} ldos_kind_t;

	// ==========================================================
	// Carriers
	typedef struct packed {
		logic signed [63:0] t1;
		logic signed [63:0] t2p;
		logic signed [63:0] t3;
		logic signed [63:0] t4p;
	} ldos_meas_t;

	typedef struct packed {
		logic signed [63:0] txm;
		logic signed [63:0] rxm;
		logic signed [63:0] txs_min;
		logic signed [63:0] rxs_min;
	} ldos_fixed_t;

	typedef struct packed {
		ldos_kind_t         kind;
		logic signed [63:0] value;
	} ldos_corr_t;

	typedef struct packed {
		logic [127:0] n;
		logic [63:0]  d;
		logic         neg;
	} ldos_div_t;

endpackage : ldos_pkg

// ==== core/ldos_servo.sv ====
// Link delay compensation and three step clock offset servo
`timescale 1ns/1ps
`default_nettype none

module ldos_servo #(
	parameter longint DRIFT_GAP = ldos_pkg::DRIFT_GAP_CYC
) (
	// System clock and reset
	input  wire logic                 clk_i,
	input  wire logic                 rst_n_i,
	// Link clock domain
	input  wire logic                 link_clk_i,
	input  wire logic                 link_up_i,
	input  wire logic [9:0]           rx_word_i,
	input  wire logic [9:0]           tx_data_i,
	output logic      [9:0]           tx_word_o,
	output logic                      comma_align_en_o,
	output logic                      bitslip_o,
	// Calibration control and phase detector
	input  wire logic                 cal_start_i,
	input  wire logic                 pd_valid_i,
	input  wire logic signed [63:0]   pd_phase_i,
	output logic                      partner_cal_req_o,
	output logic                      cal_done_o,
	// Coefficient
	input  wire logic                 alpha_load_i,
	input  wire logic signed [63:0]   alpha_i,
	input  wire logic                 alpha_cal_i,
	input  wire logic signed [63:0]   lab_offset_i,
	output logic signed [63:0]        alpha_o,
	// Measurements
	input  wire logic                 syntonized_i,
	input  wire logic                 meas_valid_i,
	input  wire ldos_pkg::ldos_meas_t meas_i,
	input  wire ldos_pkg::ldos_fixed_t fixed_i,
	// Results and corrections
	output logic signed [63:0]        round_trip_delay_o,
	output logic signed [63:0]        master_to_slave_delay_o,
	output logic signed [63:0]        master_slave_offset_o,
	output ldos_pkg::ldos_corr_t      corr_o,
	output logic                      corr_valid_o,
	output logic                      locked_o,
	output logic                      busy_o
);
	import ldos_pkg::*;

	// ==========================================================
	// Helpers
	function automatic logic signed [127:0] sx(input logic signed [63:0] v);
		sx = {{64{v[63]}}, v};
	endfunction : sx

	function automatic ldos_div_t div_setup(input logic signed [127:0] num,
		input logic signed [63:0] den);
		ldos_div_t r;
		r.n   = num[127] ? 128'(-num) : num;
		r.d   = den[63] ? 64'(-den) : den;
		r.neg = num[127] ^ den[63];
		div_setup = r;
	endfunction : div_setup

	// Floor toward minus infinity for a negative quotient
	function automatic logic signed [63:0] div_res(input logic [63:0] q,
		input logic neg, input logic rem_nz);
		if (neg && rem_nz) begin
			div_res = -$signed(q) - 64'sd1;
		end else if (neg) begin
			div_res = -$signed(q);
		end else begin
			div_res = $signed(q);
		end
	endfunction : div_res

	function automatic logic signed [63:0] clamp_var(input logic signed [63:0] v);
		if (v < 0) begin
			clamp_var = '0;
		end else if (v > VAR_MAX_PS) begin
			clamp_var = VAR_MAX_PS;
		end else begin
			clamp_var = v;
		end
	endfunction : clamp_var

	function automatic logic is_comma(input logic [9:0] w);
		is_comma = (w == COMMA_NEG) || (w == COMMA_POS);
	endfunction : is_comma

	// ==========================================================
	// Link domain: reset, pin and control synchronisers
	logic lrst_m_q, lrst_n_q, up_m_q, up_s_q;
	logic act_m_q, act_s_q, txp_m_q, txp_s_q;
	logic cal_act_q, cal_tx_q;

	always_ff @(posedge link_clk_i) begin
		lrst_m_q <= rst_n_i;
		lrst_n_q <= lrst_m_q;
		up_m_q   <= link_up_i;
		up_s_q   <= up_m_q;
		act_m_q  <= cal_act_q;
		act_s_q  <= act_m_q;
		txp_m_q  <= cal_tx_q;
		txp_s_q  <= txp_m_q;
	end

	// ==========================================================
	// Link domain: alignment search and line output
	logic       done_q, done_d, slip_q, slip_d, cen_q, cen_d;
	logic [3:0] hits_q, hits_d, win_q, win_d, wait_q, wait_d, slips_q, slips_d;
	logic [9:0] txw_q, txw_d;

	always_comb begin
		done_d  = done_q;
		hits_d  = hits_q;
		win_d   = win_q;
		wait_d  = wait_q;
		slips_d = slips_q;
		slip_d  = 1'b0;
		if (!up_s_q) begin
			done_d  = 1'b0;
			hits_d  = '0;
			win_d   = '0;
			wait_d  = '0;
			slips_d = '0;
		end else if (!done_q && wait_q != 4'h0) begin
			wait_d = wait_q - 4'h1;
		end else if (!done_q) begin
			hits_d = hits_q + {3'h0, is_comma(rx_word_i)};
			win_d  = win_q + 4'h1;
			if (win_q == WIN_LAST && hits_d >= ALIGN_HITS) begin
				done_d = 1'b1;
			end else if (win_q == WIN_LAST) begin
				slip_d  = 1'b1;
				hits_d  = '0;
				wait_d  = SLIP_WAIT;
				slips_d = (slips_q == SLIP_LAST) ? 4'h0 : slips_q + 4'h1;
			end
		end
		// comma unit off while searching or calibrating
		cen_d = !((up_s_q && !done_q) || act_s_q);
		txw_d = txp_s_q ? K28_CAL_PAT : tx_data_i;
	end

	always_ff @(posedge link_clk_i) begin
		if (!lrst_n_q) begin
			done_q  <= 1'b0;
			hits_q  <= '0;
			win_q   <= '0;
			wait_q  <= '0;
			slips_q <= '0;
			slip_q  <= 1'b0;
			cen_q   <= 1'b0;
			txw_q   <= '0;
		end else begin
			done_q  <= done_d;
			hits_q  <= hits_d;
			win_q   <= win_d;
			wait_q  <= wait_d;
			slips_q <= slips_d;
			slip_q  <= slip_d;
			cen_q   <= cen_d;
			txw_q   <= txw_d;
		end
	end

	assign tx_word_o        = txw_q;
	assign comma_align_en_o = cen_q;
	assign bitslip_o        = slip_q;

	// ==========================================================
	// System domain: calibration sequence
	// The slip count is only read once the synced done level is high,
	// so it is stable across the crossing.
	logic               dn_m_q, dn_s_q;
	ldos_cal_st_t       cst_q, cst_d;
	logic               cal_act_d, cal_tx_d;
	logic signed [63:0] txv_q, txv_d, rxv_q, rxv_d;
	logic [3:0]         slp_q, slp_d;

	always_comb begin
		cst_d     = cst_q;
		txv_d     = txv_q;
		rxv_d     = rxv_q;
		slp_d     = slp_q;
		unique case (cst_q)
			C_IDLE: if (dn_s_q) begin
				slp_d = slips_q;
				cst_d = C_WAIT;
			end
			C_WAIT: if (cal_start_i) begin
				cst_d = C_TX;
			end
			C_TX: if (pd_valid_i) begin
				txv_d = clamp_var(pd_phase_i);
				cst_d = C_RX;
			end
			C_RX: if (pd_valid_i) begin
				rxv_d = clamp_var(pd_phase_i);
				cst_d = C_DONE;
			end
			C_DONE: if (cal_start_i) begin
				cst_d = C_TX;
			end
		endcase
		if (!dn_s_q) begin
			cst_d = C_IDLE;
		end
		cal_act_d = (cst_d == C_TX) || (cst_d == C_RX);
		cal_tx_d  = (cst_d == C_TX);
	end

	always_ff @(posedge clk_i) begin
		dn_m_q <= done_q;
		dn_s_q <= dn_m_q;
		if (!rst_n_i) begin
			cst_q     <= C_IDLE;
			txv_q     <= '0;
			rxv_q     <= '0;
			slp_q     <= '0;
			cal_act_q <= 1'b0;
			cal_tx_q  <= 1'b0;
		end else begin
			cst_q     <= cst_d;
			txv_q     <= txv_d;
			rxv_q     <= rxv_d;
			slp_q     <= slp_d;
			cal_act_q <= cal_act_d;
			cal_tx_q  <= cal_tx_d;
		end
	end

	assign partner_cal_req_o = (cst_q == C_RX);
	assign cal_done_o        = (cst_q == C_DONE);

	// ==========================================================
	// System domain: delay, offset and correction servo
	ldos_srv_st_t       sst_q, sst_d, ret_q, ret_d;
	ldos_div_t          dv_q, dv_d;
	logic [64:0]        rem_q, rem_d, rem_sh;
	logic [7:0]         cnt_q, cnt_d;
	logic signed [63:0] alpha_q, alpha_d, rtd_q, rtd_d, dms_q, dms_d;
	logic signed [63:0] off_q, off_d, prev_q, prev_d, res_q, res_d;
	logic signed [63:0] t1_q, t1_d, t2_q, t2_d, dfix, rtd_c, q_c, dlt_c;
	logic signed [127:0] num_c;
	ldos_corr_t         corr_q, corr_d;
	logic               cv_q, cv_d, lock_q, lock_d;
	longint             gap_q, gap_d;

	always_comb begin
		sst_d  = sst_q;
		ret_d  = ret_q;
		dv_d   = dv_q;
		rem_d  = rem_q;
		cnt_d  = cnt_q;
		alpha_d = alpha_q;
		rtd_d  = rtd_q;
		dms_d  = dms_q;
		off_d  = off_q;
		prev_d = prev_q;
		res_d  = res_q;
		t1_d   = t1_q;
		t2_d   = t2_q;
		corr_d = corr_q;
		cv_d   = 1'b0;
		lock_d = lock_q;
		gap_d  = (gap_q < DRIFT_GAP) ? gap_q + 1 : gap_q;
		// master delays plus slave delays: minimum plus measured part and slip bits
		dfix = fixed_i.txm + fixed_i.rxm + fixed_i.txs_min + txv_q
			+ fixed_i.rxs_min + rxv_q + 64'(slp_q) * 64'(BIT_PS);
		rtd_c = (meas_i.t4p - meas_i.t1) - (meas_i.t3 - meas_i.t2p);
		rem_sh = {rem_q[63:0], dv_q.n[127]};
		q_c    = div_res(dv_q.n[63:0], dv_q.neg, rem_q != 65'h0);
		dlt_c  = q_c + fixed_i.txm + fixed_i.rxs_min + rxv_q
			+ 64'(slp_q) * 64'(BIT_PS);
		num_c  = '0;
		unique case (sst_q)
			S_IDLE: begin
				if (alpha_load_i) begin
					alpha_d = alpha_i;
				end
				if (alpha_cal_i && cal_done_o) begin
					num_c = sx(rtd_c - dfix + (lab_offset_i <<< 1)) <<< FRAC_W;
					dv_d  = div_setup(num_c, rtd_c - dfix - (lab_offset_i <<< 1));
					ret_d = S_ACAL;
					sst_d = S_DIV;
				end else if (meas_valid_i && cal_done_o && syntonized_i
					&& (!lock_q || gap_q >= DRIFT_GAP)) begin
					rtd_d = rtd_c;
					t1_d  = meas_i.t1;
					t2_d  = meas_i.t2p;
					num_c = sx(ALPHA_ONE + alpha_q) * sx(rtd_c - dfix);
					dv_d  = div_setup(num_c, (ALPHA_ONE <<< 1) + alpha_q);
					ret_d = S_MSD;
					sst_d = S_DIV;
				end
				rem_d = '0;
				cnt_d = DIV_STEPS;
			end
			// Restoring divide, one quotient bit per cycle
			S_DIV: begin
				dv_d.n = {dv_q.n[126:0], rem_sh >= {1'b0, dv_q.d}};
				rem_d  = (rem_sh >= {1'b0, dv_q.d}) ? rem_sh - {1'b0, dv_q.d}
					: rem_sh;
				cnt_d  = cnt_q - 8'h1;
				if (cnt_q == 8'h1) begin
					sst_d = ret_q;
				end
			end
			S_MSD: begin
				// add master tx and slave rx
				dms_d = dlt_c;
				off_d = t1_q - t2_q - dlt_c;
				rem_d = '0;
				cnt_d = DIV_STEPS;
				if (!lock_q) begin
					dv_d  = div_setup(sx(off_d), SEC_PS);
					ret_d = S_SEC;
					sst_d = S_DIV;
				end else begin
					corr_d = '{K_DRIFT, off_d - prev_q};
					cv_d   = 1'b1;
					prev_d = off_d;
					gap_d  = 0;
					sst_d  = S_IDLE;
				end
			end
			S_SEC: begin
				corr_d = '{K_SEC, q_c};
				cv_d   = 1'b1;
				res_d  = off_q - q_c * SEC_PS;
				dv_d   = div_setup(sx(res_d), T_REF_PS);
				rem_d  = '0;
				cnt_d  = DIV_STEPS;
				ret_d  = S_CYC;
				sst_d  = S_DIV;
			end
			S_CYC: begin
				corr_d = '{K_CYC, q_c};
				cv_d   = 1'b1;
				res_d  = res_q - q_c * T_REF_PS;
				sst_d  = S_PH;
			end
			S_PH: begin
				corr_d = '{K_PHASE, res_q};
				cv_d   = 1'b1;
				prev_d = off_q;
				lock_d = 1'b1;
				gap_d  = 0;
				sst_d  = S_IDLE;
			end
			S_ACAL: begin
				alpha_d = q_c - ALPHA_ONE;
				sst_d   = S_IDLE;
			end
		endcase
		if (!cal_done_o) begin
			lock_d = 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			sst_q   <= S_IDLE;
			ret_q   <= S_IDLE;
			dv_q    <= '0;
			rem_q   <= '0;
			cnt_q   <= '0;
			alpha_q <= ALPHA_RST;
			rtd_q   <= '0;
			dms_q   <= '0;
			off_q   <= '0;
			prev_q  <= '0;
			res_q   <= '0;
			t1_q    <= '0;
			t2_q    <= '0;
			corr_q  <= '{K_SEC, 64'sh0};
			cv_q    <= 1'b0;
			lock_q  <= 1'b0;
			gap_q   <= 0;
		end else begin
			sst_q   <= sst_d;
			ret_q   <= ret_d;
			dv_q    <= dv_d;
			rem_q   <= rem_d;
			cnt_q   <= cnt_d;
			alpha_q <= alpha_d;
			rtd_q   <= rtd_d;
			dms_q   <= dms_d;
			off_q   <= off_d;
			prev_q  <= prev_d;
			res_q   <= res_d;
			t1_q    <= t1_d;
			t2_q    <= t2_d;
			corr_q  <= corr_d;
			cv_q    <= cv_d;
			lock_q  <= lock_d;
			gap_q   <= gap_d;
		end
	end

	// every step leaves as a relative value
	assign corr_o                  = corr_q;
	assign corr_valid_o            = cv_q;
	assign alpha_o                 = alpha_q;
	assign round_trip_delay_o      = rtd_q;
	assign master_to_slave_delay_o = dms_q;
	assign master_slave_offset_o   = off_q;
	assign locked_o                = lock_q;
	assign busy_o                  = (sst_q != S_IDLE);

	// ==========================================================
	// Checks
	property p_pattern;
		@(posedge link_clk_i) disable iff (!lrst_n_q)
		$past(txp_s_q) |-> tx_word_o == K28_CAL_PAT;
	endproperty
	a_pattern: assert property (p_pattern) else $error("pattern missing");

	property p_comma_off;
		@(posedge link_clk_i) disable iff (!lrst_n_q)
		$past(act_s_q) |-> !comma_align_en_o;
	endproperty
	a_comma_off: assert property (p_comma_off) else $error("comma unit on");

	property p_slip;
		@(posedge link_clk_i) disable iff (!lrst_n_q)
		bitslip_o |-> !comma_align_en_o ##1 !bitslip_o [*3];
	endproperty
	a_slip: assert property (p_slip) else $error("bad slip spacing");

	property p_partner;
		@(posedge clk_i) disable iff (!rst_n_i)
		(cst_q == C_TX && pd_valid_i && dn_s_q) |=> partner_cal_req_o;
	endproperty
	a_partner: assert property (p_partner) else $error("no partner request");

	property p_unlock;
		@(posedge clk_i) disable iff (!rst_n_i)
		!dn_s_q |=> !cal_done_o ##1 !locked_o;
	endproperty
	a_unlock: assert property (p_unlock) else $error("kept latency on unlock");

	property p_synt;
		@(posedge clk_i) disable iff (!rst_n_i)
		(!busy_o && !syntonized_i && !alpha_cal_i) |=> !busy_o;
	endproperty
	a_synt: assert property (p_synt) else $error("started unsyntonized");

	sequence s_sec;
		corr_valid_o && corr_o.kind == K_SEC;
	endsequence
	sequence s_cyc;
		corr_valid_o && corr_o.kind == K_CYC;
	endsequence
	property p_order;
		@(posedge clk_i) disable iff (!rst_n_i)
		// One full divide separates the seconds and cycle steps
		s_sec |-> ##129 s_cyc ##1 (corr_valid_o && corr_o.kind == K_PHASE);
	endproperty
	a_order: assert property (p_order) else $error("steps out of order");

	property p_phase_rng;
		@(posedge clk_i) disable iff (!rst_n_i)
		(corr_valid_o && corr_o.kind == K_PHASE) |->
			corr_o.value >= 0 && corr_o.value < T_REF_PS && locked_o;
	endproperty
	a_phase_rng: assert property (p_phase_rng) else $error("phase out of range");

	property p_drift;
		@(posedge clk_i) disable iff (!rst_n_i)
		(corr_valid_o && corr_o.kind == K_DRIFT) |->
			corr_o.value == master_slave_offset_o - $past(prev_q);
	endproperty
	a_drift: assert property (p_drift) else $error("drift step wrong");

	property p_clamp;
		@(posedge clk_i) disable iff (!rst_n_i)
		txv_q >= 0 && txv_q <= VAR_MAX_PS && rxv_q >= 0 && rxv_q <= VAR_MAX_PS;
	endproperty
	a_clamp: assert property (p_clamp) else $error("latency out of spread");

endmodule : ldos_servo

`default_nettype wire

// ==== tb/ldos_link_partner.sv ====
// Behavioural far end of the link: comma stream or calibration pattern
`timescale 1ns/1ps
`default_nettype none

module ldos_link_partner #(
	parameter int SLIPS_NEEDED = 2
) (
	// Link clock, calibration request and slip pulses from the servo
	input  wire logic       link_clk_i,
	input  wire logic       cal_req_i,
	input  wire logic       bitslip_i,
	// Words toward the servo
	output var  logic [9:0] rx_word_o
);
	import ldos_pkg::*;

	logic [1:0] req_sync_q = 2'h0;
	logic [1:0] slot_q     = 2'h0;
	int         slips_q    = 0;

	// ==========================================================
	// Request crosses into the link clock before it changes the stream
	always_ff @(posedge link_clk_i) begin
		req_sync_q <= {req_sync_q[0], cal_req_i};
		slot_q     <= slot_q + 2'h1;
		// Word boundary only lines up after the servo has slipped enough
		if (bitslip_i && slips_q < SLIPS_NEEDED) begin
			slips_q <= slips_q + 1;
		end
	end

	// Commas are interleaved with data so an aligned window is unambiguous
	// pattern on request
	always_ff @(posedge link_clk_i) begin
		if (req_sync_q[1]) begin
			rx_word_o <= K28_CAL_PAT;
		end else if (slips_q < SLIPS_NEEDED) begin
			// Misaligned boundary: no comma is recognisable yet
			rx_word_o <= 10'h155;
		end else begin
			case (slot_q)
				2'h0: rx_word_o <= COMMA_POS;
				2'h2: rx_word_o <= COMMA_NEG;
				default: rx_word_o <= 10'h155;
			endcase
		end
	end
endmodule : ldos_link_partner
`default_nettype wire

// ==== tb/ldos_servo_tb.sv ====
// Self-checking bench of the link delay and offset servo
`timescale 1ns/1ps
`default_nettype none

module ldos_servo_tb;
	import ldos_pkg::*;

	localparam longint T1  = 64'sd5000000000000;
	localparam longint T2P = T1 + SEC_PS - 103900;
	localparam int     SLIPS = 2;
	logic               clk_i, rst_n_i, link_clk_i, link_up_i;
	logic [9:0]         rx_word, tx_data, tx_word;
	logic               comma_en, bitslip, cal_start, pd_valid;
	logic signed [63:0] pd_phase, alpha_in, alpha_out, rtd, dms, off;
	logic               cal_req, cal_done, alpha_load, synt, meas_valid;
	ldos_meas_t         meas;
	ldos_fixed_t        fixed;
	ldos_corr_t         corr;
	logic               corr_valid, locked, busy;
	logic               alpha_cal;
	logic signed [63:0] lab_off;
	int                 err_total, comparisons, cycles;

	ldos_servo #(.DRIFT_GAP(10)) u_ldos_servo (
		.clk_i(clk_i), .rst_n_i(rst_n_i), .link_clk_i(link_clk_i),
		.link_up_i(link_up_i), .rx_word_i(rx_word), .tx_data_i(tx_data),
		.tx_word_o(tx_word), .comma_align_en_o(comma_en),
		.bitslip_o(bitslip), .cal_start_i(cal_start),
		.pd_valid_i(pd_valid), .pd_phase_i(pd_phase),
		.partner_cal_req_o(cal_req), .cal_done_o(cal_done),
		.alpha_load_i(alpha_load), .alpha_i(alpha_in),
		.alpha_cal_i(alpha_cal), .lab_offset_i(lab_off), .alpha_o(alpha_out),
		.syntonized_i(synt), .meas_valid_i(meas_valid), .meas_i(meas),
		.fixed_i(fixed), .round_trip_delay_o(rtd),
		.master_to_slave_delay_o(dms), .master_slave_offset_o(off),
		.corr_o(corr), .corr_valid_o(corr_valid), .locked_o(locked),
		.busy_o(busy));

	ldos_link_partner #(.SLIPS_NEEDED(SLIPS)) u_ldos_link_partner (
		.link_clk_i(link_clk_i), .cal_req_i(cal_req), .bitslip_i(bitslip),
		.rx_word_o(rx_word));

	// ==========================================================
	// Clocks: the link clock is skewed so its edges never meet clk_i
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	initial begin
		link_clk_i = 1'b0;
		#3.7;
		forever #80 link_clk_i = ~link_clk_i;
	end

	// Hang guard
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			err_total++;
			conclude();
		end
	end

	// ==========================================================
	// Helpers
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask : tick

	task automatic check(input logic [63:0] seen, input logic [63:0] exp,
		input string what);
		comparisons++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value at %0t: %s seen %h expected %h", $time, what,
				seen, exp);
		end
	endtask : check

	function automatic longint fdiv(input longint a, input longint b);
		longint q;
		q = a / b;
		if ((a % b != 0) && ((a < 0) != (b < 0))) begin
			q = q - 1;
		end
		return q;
	endfunction : fdiv

	task automatic send(input longint shift);
		meas.t1 = T1;
		meas.t2p = T2P - shift;
		meas.t3 = T2P + 50000 - shift;
		meas.t4p = T1 + 264000;
		meas_valid = 1'b1;
		tick(1);
		meas_valid = 1'b0;
	endtask : send

	task automatic wait_corr(input logic [3:0] kind, input longint val);
		int i;
		for (i = 0; i < 600 && corr_valid !== 1'b1; i++) tick(1);
		check(64'(corr.kind), 64'(kind), "correction kind");
		check(corr.value, val, "correction value");
		tick(1);
	endtask : wait_corr

	task automatic pd_pulse(input longint ps);
		pd_phase = ps;
		pd_valid = 1'b1;
		tick(1);
		pd_valid = 1'b0;
		tick(1);
	endtask : pd_pulse

	// ==========================================================
	// Scenarios
	task automatic t_reset();
		check(alpha_out, ALPHA_RST, "coefficient at reset");
		check(64'(comma_en), 64'h0, "comma align at reset");
		cal_start = 1'b1;
		tick(1);
		cal_start = 1'b0;
		tick(3);
		check(64'(cal_req), 64'h0, "calibration before alignment");
		$display("test reset done");
	endtask : t_reset

	task automatic t_align();
		int i;
		link_up_i = 1'b1;
		for (i = 0; i < 4000 && comma_en !== 1'b1; i++) tick(1);
		check(64'(comma_en), 64'h1, "alignment found");
		check(64'(bitslip), 64'h0, "no slip once aligned");
		tick(10);
		$display("test align done");
	endtask : t_align

	task automatic t_cal();
		cal_start = 1'b1;
		tick(1);
		cal_start = 1'b0;
		tick(80);
		check(64'(tx_word), 64'(K28_CAL_PAT), "tx pattern");
		check(64'(comma_en), 64'h0, "comma align off");
		pd_pulse(1600);
		check(64'(cal_req), 64'h1, "partner asked");
		pd_pulse(2400);
		check(64'(cal_req), 64'h0, "partner released");
		check(64'(cal_done), 64'h1, "latencies valid");
		tick(80);
		check(64'(tx_word), 64'(tx_data), "normal tx word");
		check(64'(comma_en), 64'h1, "comma align back");
		$display("test calibration done");
	endtask : t_cal

	task automatic t_run();
		longint delta, exp_dms, exp_off, sec, cyc, exp_alpha;
		int i;
		// Each slip the partner forced adds one bit time to the rx path
		delta = 1000 + 2000 + (3000 + 1600) + (4000 + 2400 + SLIPS * BIT_PS);
		exp_dms = (214000 - delta) / 2 + 1000 + 4000 + 2400 + SLIPS * BIT_PS;
		exp_off = T1 - T2P - exp_dms;
		sec = fdiv(exp_off, SEC_PS);
		cyc = fdiv(exp_off - sec * SEC_PS, T_REF_PS);
		alpha_in = 64'sh0;
		alpha_load = 1'b1;
		tick(1);
		alpha_load = 1'b0;
		send(0);
		tick(3);
		check(64'(busy), 64'h0, "not syntonized");
		synt = 1'b1;
		send(0);
		tick(2);
		check(rtd, 64'sd214000, "round trip");
		wait_corr(K_SEC, sec);
		check(dms, exp_dms, "master to slave delay");
		check(off, exp_off, "offset");
		wait_corr(K_CYC, cyc);
		wait_corr(K_PHASE, exp_off - sec * SEC_PS - cyc * T_REF_PS);
		tick(3);
		check(64'(locked), 64'h1, "coarse done");
		tick(20);
		send(300);
		wait_corr(K_DRIFT, 300);
		for (i = 0; i < 50 && busy !== 1'b0; i++) tick(1);
		send(300);
		tick(3);
		check(64'(busy), 64'h0, "drift gap holds");
		alpha_cal = 1'b1;
		tick(1);
		alpha_cal = 1'b0;
		for (i = 0; i < 200 && busy !== 1'b0; i++) tick(1);
		// Ratio of the lab equations, stored minus one
		exp_alpha = ((214000 - delta + 2 * lab_off) <<< 32)
			/ (214000 - delta - 2 * lab_off) - (64'sd1 <<< 32);
		check(alpha_out, exp_alpha, "lab coefficient");
		$display("test servo done");
	endtask : t_run

	task automatic t_unlock();
		link_up_i = 1'b0;
		tick(80);
		check(64'(cal_done), 64'h0, "latencies dropped");
		check(64'(locked), 64'h0, "lock dropped");
		$display("test unlock done");
	endtask : t_unlock

	task automatic conclude();
		$display("counts: %0d comparisons, %0d mismatches", comparisons,
			err_total);
		if (err_total == 0 && comparisons > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : conclude

	// ==========================================================
	// Main sequence; reset spans several link cycles so both domains clear
	initial begin
		rst_n_i = 1'b0;
		link_up_i = 1'b0;
		tx_data = 10'h1A5;
		cal_start = 1'b0;
		pd_valid = 1'b0;
		pd_phase = 64'sh0;
		alpha_load = 1'b0;
		alpha_in = 64'sh0;
		synt = 1'b0;
		alpha_cal = 1'b0;
		lab_off = 64'sd100;
		meas_valid = 1'b0;
		meas = '0;
		fixed = '{txm: 1000, rxm: 2000, txs_min: 3000, rxs_min: 4000};
		err_total = 0;
		comparisons = 0;
		cycles = 0;
		repeat (64) @(posedge clk_i);
		#1 rst_n_i = 1'b1;
		tick(1);
		t_reset();
		t_align();
		t_cal();
		t_run();
		t_unlock();
		conclude();
	end
endmodule : ldos_servo_tb
`default_nettype wire
